// *** include/cfsp_pkg.sv ***
// Purpose: shared constants for the clock supervision and reset block
// Assumes: clk at 100 MHz, one 32-bit APB register word
// Notes: unlock keys, group codes, field positions and delays
//
// Summary of operation
// - monitor on keeps low-power RC running, except sleep
// - oscillator failure raises trap, moves to fast RC
// - failure: load group, set fail flag, clear enable
// - failure leaves watchdog clock untouched
// - slow start after power-up traps to fast RC
// - switch among four groups; primary option from fuse
// - current group read-only; new group writable
// - power-up loads both group fields from fuse
// - show PLL lock and read-only fail flag
// - enable clears once switch done; clearing it aborts
// - fuse field 1x disables switching and monitoring
// - switching off: fuses select, current group reports
// - low byte unlocked by 0x46 then 0x57
// - high byte unlocked by 0x78 then 0x9A
// - unlocked byte write open for one transfer
// - wait 10 us bias plus 0/4/16/64 ms
// - reset released on first quadrature phase edge
// - monitor on, clock not ready: trap, run fast RC
// - no monitor, no timer: leave reset quickly
// - no monitor, no clock: stay frozen in reset
// - pin reset filtered; internal resets never drive pin
// - watchdog wake-up leaves registers unchanged
// - current group code 001 means fast RC
package cfsp_pkg;
    localparam logic [11:0] OSC_CTRL_OFS = 12'h000; // register byte address
    localparam int CUR_LSB  = 12;                   // current group 14:12
    localparam int NEW_LSB  = 8;                    // new group 10:8
    localparam int LOCK_BIT = 5;                    // pll lock status
    localparam int CF_BIT   = 3;                    // clock fail flag
    localparam int SWEN_BIT = 0;                    // switch enable
    localparam logic [2:0] GRP_SEC  = 3'h0;         // secondary
    localparam logic [2:0] GRP_FRC  = 3'h1;         // fast rc
    localparam logic [2:0] GRP_LOW_POWER_RC = 3'h2;         // low-power rc
    localparam logic [2:0] GRP_PRI  = 3'h3;         // primary, no pll
    localparam logic [2:0] GRP_PLL  = 3'h7;         // primary with pll
    localparam logic [7:0] KEY_LO1 = 8'h46;         // low byte keys
    localparam logic [7:0] KEY_LO2 = 8'h57;
    localparam logic [7:0] KEY_HI1 = 8'h78;         // high byte keys
    localparam logic [7:0] KEY_HI2 = 8'h9A;
    localparam logic [3:0] STRB_LO = 4'h1;          // byte lane 0 only
    localparam logic [3:0] STRB_HI = 4'h2;          // byte lane 1 only
    localparam int CLK_NS    = 10;                  // clock period
    localparam int BIAS_NS   = 10000;               // 10 us bias settle
    localparam int BIAS_CYC  = (BIAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int NS_PER_MS = 1000000;
    localparam int PWRT4_MS  = 4;                   // power-up delays
    localparam int PWRT16_MS = 16;
    localparam int PWRT64_MS = 64;
    localparam int CNT_W     = 23;                  // holds 64 ms count
    localparam int FILT_CYC  = 4;                   // pin glitch filter
    localparam logic [2:0] RST_GRP = 3'h1;          // before fuse load
    typedef enum logic [1:0] {LK_IDLE, LK_KEY1, LK_OPEN} cfsp_lock_t;
    typedef enum logic [3:0] {
        ST_BIAS, ST_POWER_UP_TIMER, ST_CHECK, ST_FREEZE, ST_RUN,
        ST_SWITCH, ST_F_GRP, ST_F_CF, ST_F_SW
    } cfsp_state_t;
endpackage

// *** design/cfsp_rst_filter.sv ***
// Purpose: glitch filter for the external reset pin
// Assumes: pin level already synchronous to clk
// Notes: state flips only after a steady run of samples
`timescale 1ns/1ps
module cfsp_rst_filter
    import cfsp_pkg::*;
#(
    parameter int FILT_LEN = FILT_CYC  // samples needed to flip
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin_n,           // raw pin, low = reset
    output logic      rst_req          // filtered reset request
);
    localparam int CW = $clog2(FILT_LEN + 1);
    logic [CW-1:0] run_ff;             // steady-sample counter
    logic          req_ff;             // filtered state

    // short pulses never reach the counter's end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_ff <= '0;
            req_ff <= 1'b0;
        end else if (pin_n != req_ff) begin
            run_ff <= '0;              // pin agrees, no change
        end else if (run_ff == CW'(FILT_LEN - 1)) begin
            run_ff <= '0;
            req_ff <= ~req_ff;         // steady long enough
        end else begin
            run_ff <= run_ff + 1'b1;
        end
    end

    // pin is input only: internal resets cannot pull it
    assign rst_req = req_ff;
endmodule

// *** design/cfsp_top.sv ***
// Purpose: clock fail-safe, keyed clock switch, power-up sequencing
// Assumes: APB slave, zero wait states, clk 100 MHz
// Notes: long power-up counts are parameters for simulation
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
module cfsp_top
    import cfsp_pkg::*;
#(
    parameter int PWRT4_CYC  = PWRT4_MS * (NS_PER_MS / CLK_NS),
    parameter int PWRT16_CYC = PWRT16_MS * (NS_PER_MS / CLK_NS),
    parameter int PWRT64_CYC = PWRT64_MS * (NS_PER_MS / CLK_NS)
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  group_fuse,
    input  wire logic [4:0]  primary_mode_fuse,
    input  wire logic [1:0]  switch_monitor_fuse,
    input  wire logic [1:0]  power_up_timer_fuse,
    input  wire logic        soft_watchdog_enable,
    input  wire logic        sleep_mode,
    input  wire logic        watchdog_wake,
    input  wire logic        external_reset_pin_n,
    input  wire logic        first_quadrature_phase,
    input  wire logic        osc_running,
    input  wire logic        oscillator_startup_done,
    input  wire logic        pll_locked,
    input  wire logic        group_ready,
    output logic [2:0]       active_group,
    output logic [4:0]       primary_mode,
    output logic [2:0]       osc_request_group,
    output logic             fast_rc_run,
    output logic             low_power_rc_enable,
    output logic             clock_fail_trap,
    output logic             internal_system_reset
);
    // group code is one of the four switchable groups
    function automatic logic grp_legal(logic [2:0] g);
        grp_legal = (g == GRP_SEC) || (g == GRP_FRC) ||
                    (g == GRP_LOW_POWER_RC) || grp_pri(g);
    endfunction

    // primary group, with or without pll
    function automatic logic grp_pri(logic [2:0] g);
        grp_pri = (g == GRP_PRI) || (g == GRP_PLL);
    endfunction

    // unlock step for one byte lane; any other transfer drops it
    function automatic cfsp_lock_t lock_next(cfsp_lock_t st,
                                             logic hit,
                                             logic [7:0] d,
                                             logic [7:0] k1,
                                             logic [7:0] k2);
        if (st == LK_OPEN)
            lock_next = LK_IDLE;              // window is one transfer
        else if (hit && st == LK_KEY1 && d == k2)
            lock_next = LK_OPEN;
        else if (hit && d == k1)
            lock_next = LK_KEY1;
        else
            lock_next = LK_IDLE;
    endfunction

    cfsp_state_t       state_ff;              // sequencing state
    cfsp_state_t       nxt_state;
    cfsp_lock_t        lo_lk_ff;              // low byte unlock
    cfsp_lock_t        hi_lk_ff;              // high byte unlock
    logic [CNT_W-1:0]  cnt_ff;                // delay counter
    logic [CNT_W-1:0]  power_up_timer_lim;              // selected delay
    logic [2:0]        cur_ff;                // current group
    logic [2:0]        new_ff;                // requested group
    logic              cf_ff;                 // clock fail flag
    logic              swen_ff;               // switch enable
    logic              internal_system_reset_ff;             // internal reset
    logic              trap_ff;               // trap pulse
    logic [31:0]       prdata_ff;
    logic              pslverr_ff;
    logic [15:0]       reg_img;               // register read image
    logic              ext_rst;               // filtered pin reset
    logic              switch_on;
    logic              monitor_on;
    logic              clk_bad;
    logic              xfer;
    logic              addr_ok;
    logic              lo_wr;
    logic              hi_wr;
    logic              apply_lo;
    logic              apply_hi;
    logic              in_powerup;

    cfsp_rst_filter u_filt (
        .clk     (clk),
        .reset   (reset),
        .pin_n   (external_reset_pin_n),
        .rst_req (ext_rst)
    );

    // fuse field 1x turns both functions off
    assign switch_on  = ~switch_monitor_fuse[1];
    assign monitor_on = (switch_monitor_fuse == 2'b00);
    assign in_powerup = (state_ff == ST_BIAS) ||
                        (state_ff == ST_POWER_UP_TIMER);

    // clock not usable: dead, still starting, or pll unlocked
    assign clk_bad = ~osc_running ||
                     (grp_pri(cur_ff) && ~oscillator_startup_done) ||
                     ((cur_ff == GRP_PLL) && ~pll_locked);

    // apb decode; each completed transfer is one instruction
    assign xfer     = psel && penable;
    assign addr_ok  = (paddr == OSC_CTRL_OFS);
    assign lo_wr    = xfer && pwrite && addr_ok && (pstrb == STRB_LO);
    assign hi_wr    = xfer && pwrite && addr_ok && (pstrb == STRB_HI);
    assign apply_lo = lo_wr && (lo_lk_ff == LK_OPEN);
    assign apply_hi = hi_wr && (hi_lk_ff == LK_OPEN);

    // selected power-up delay, zero means none
    always_comb begin
        case (power_up_timer_fuse)
            2'b01:   power_up_timer_lim = CNT_W'(PWRT4_CYC);
            2'b10:   power_up_timer_lim = CNT_W'(PWRT16_CYC);
            2'b11:   power_up_timer_lim = CNT_W'(PWRT64_CYC);
            default: power_up_timer_lim = '0;
        endcase
    end

    // unlock trackers; wrong key or other transfer discards
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lo_lk_ff <= LK_IDLE;
            hi_lk_ff <= LK_IDLE;
        end else if (xfer) begin
            lo_lk_ff <= lock_next(lo_lk_ff, lo_wr, pwdata[7:0],
                                  KEY_LO1, KEY_LO2);
            hi_lk_ff <= lock_next(hi_lk_ff, hi_wr, pwdata[15:8],
                                  KEY_HI1, KEY_HI2);
        end
    end

    // sequencing: power-up, check, run, switch, failure steps
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_BIAS:
                if (cnt_ff == CNT_W'(BIAS_CYC - 1))
                    nxt_state = ST_POWER_UP_TIMER;
            ST_POWER_UP_TIMER:
                if (cnt_ff >= power_up_timer_lim)
                    nxt_state = ST_CHECK;        // none: quick
            ST_CHECK:
                if (clk_bad && monitor_on)
                    nxt_state = ST_F_GRP;
                else if (clk_bad)
                    nxt_state = ST_FREEZE;
                else
                    nxt_state = ST_RUN;
            ST_FREEZE:
                if (!clk_bad)
                    nxt_state = ST_RUN;   // frozen until clock
            ST_RUN:
                if (monitor_on && !osc_running && !sleep_mode)
                    nxt_state = ST_F_GRP;
                else if (swen_ff && switch_on && grp_legal(new_ff) &&
                         new_ff != cur_ff)
                    nxt_state = ST_SWITCH;
            ST_SWITCH:
                if (!swen_ff)
                    nxt_state = ST_RUN;        // software abort
                else if (monitor_on && !osc_running)
                    nxt_state = ST_F_GRP;
                else if (group_ready)
                    nxt_state = ST_RUN;
            ST_F_GRP: nxt_state = ST_F_CF;
            ST_F_CF:  nxt_state = ST_F_SW;
            ST_F_SW:
                if (!internal_system_reset_ff)
                    nxt_state = ST_RUN;  // trap only once core runs
            default: nxt_state = ST_BIAS;
        endcase
        // pin reset rechecks the clock but keeps power-up done
        if (ext_rst && !in_powerup)
            nxt_state = ST_CHECK;
    end

    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            state_ff <= ST_BIAS;
        else
            state_ff <= nxt_state;
    end

    // delay counter, restarts at each state change
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            cnt_ff <= '0;
        else if (nxt_state != state_ff)
            cnt_ff <= '0;
        else if (in_powerup)
            cnt_ff <= cnt_ff + 1'b1;
    end

    // current group: fuse at power-up, switch result, fast rc on fail
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            cur_ff <= RST_GRP;
        else if (state_ff == ST_BIAS || !switch_on)
            cur_ff <= group_fuse;
        else if (state_ff == ST_F_GRP)
            cur_ff <= GRP_FRC;              // step one
        else if (state_ff == ST_SWITCH && swen_ff && group_ready &&
                 !(monitor_on && !osc_running))
            cur_ff <= new_ff;
    end

    // new group: fuse at power-up, then unlocked high byte
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            new_ff <= RST_GRP;
        else if (state_ff == ST_BIAS)
            new_ff <= group_fuse;
        else if (apply_hi)
            new_ff <= pwdata[NEW_LSB +: 3];
    end

    // fail flag: set by hardware only, cleared only by reset
    // a watchdog wake is not a reset, so nothing here moves
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            cf_ff <= 1'b0;
        else if (state_ff == ST_F_CF)
            cf_ff <= 1'b1;                      // step two
    end

    // switch enable: hardware clear beats a software write
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            swen_ff <= 1'b0;
        else if (state_ff == ST_F_SW)
            swen_ff <= 1'b0;                    // step three
        else if (state_ff == ST_SWITCH && group_ready)
            swen_ff <= 1'b0;                    // switch done
        else if (apply_lo && switch_on)
            swen_ff <= pwdata[SWEN_BIT];        // set or abort
    end

    // internal reset: released on a phase-one edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            internal_system_reset_ff <= 1'b1;
        else if (ext_rst)
            internal_system_reset_ff <= 1'b1;
        else if (first_quadrature_phase && !in_powerup &&
                 state_ff != ST_CHECK && state_ff != ST_FREEZE)
            internal_system_reset_ff <= 1'b0;
    end

    // trap pulse once the failure steps finish
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            trap_ff <= 1'b0;
        else
            trap_ff <= (state_ff == ST_F_SW) && !internal_system_reset_ff;
    end

    // register image; lock and fail flag are status only
    always_comb begin
        reg_img = 16'h0000;
        reg_img[CUR_LSB +: 3] = active_group;   // read-only
        reg_img[NEW_LSB +: 3] = new_ff;
        reg_img[LOCK_BIT]     = pll_locked;
        reg_img[CF_BIT]       = cf_ff;
        reg_img[SWEN_BIT]     = swen_ff;
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (psel && !penable) begin
            prdata_ff  <= (addr_ok && !pwrite) ?
                          {16'h0000, reg_img} : 32'h0000_0000;
            pslverr_ff <= !addr_ok;             // unmapped address
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = penable;                   // zero wait states
    assign pslverr = pslverr_ff && psel && penable;

    // fuses pick the clock when switching is off
    assign active_group = switch_on ? cur_ff : group_fuse;
    // option inside the primary group fixed by fuse
    assign primary_mode = grp_pri(active_group) ?
                          primary_mode_fuse : 5'h00;
    // sources start the target while a switch is pending
    assign osc_request_group = (state_ff == ST_SWITCH) ?
                               new_ff : active_group;
    assign fast_rc_run = (active_group == GRP_FRC);
    // monitor overrides the soft enable; fail path never
    // touches it, so the watchdog clock runs on
    assign low_power_rc_enable = (monitor_on && !sleep_mode) ||
                                 soft_watchdog_enable ||
                                 (active_group == GRP_LOW_POWER_RC) ||
                                 in_powerup;
    assign clock_fail_trap       = trap_ff;
    assign internal_system_reset = internal_system_reset_ff;

    // checks of the sequencing against its causes
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_fail_frc: assert property (
        (state_ff == ST_F_GRP && switch_on) |=> (cur_ff == GRP_FRC))
        else $error("failure did not move to fast rc");

    chk_fail_order: assert property (
        $rose(cf_ff) |-> (cur_ff == GRP_FRC) ##1 !swen_ff)
        else $error("failure steps out of order");

    chk_low_power_rc_on: assert property (
        (monitor_on && !sleep_mode) |-> low_power_rc_enable)
        else $error("low-power rc stopped while monitored");

    chk_open_once: assert property (
        (xfer && lo_lk_ff == LK_OPEN) |=> (lo_lk_ff != LK_OPEN))
        else $error("low byte window stayed open");

    chk_fuse_select: assert property (
        !switch_on |-> (active_group == group_fuse) && !swen_ff)
        else $error("switch active while disabled");

    chk_rel_phase: assert property (
        $fell(internal_system_reset_ff) |-> $past(first_quadrature_phase))
        else $error("reset released off phase one");

    chk_bias_len: assert property (
        (state_ff == ST_BIAS) ##1 (state_ff == ST_POWER_UP_TIMER) |->
        $past(cnt_ff, 1) == CNT_W'(BIAS_CYC - 1))
        else $error("bias delay wrong length");

    chk_check_trap: assert property (
        (state_ff == ST_CHECK && monitor_on && clk_bad && !ext_rst)
        |=> (state_ff == ST_F_GRP) ##2 (state_ff == ST_F_SW))
        else $error("unready clock did not trap");

    chk_frozen: assert property (
        (state_ff == ST_FREEZE) |-> internal_system_reset_ff)
        else $error("left reset while frozen");

    chk_abort: assert property (
        (state_ff == ST_SWITCH && !swen_ff && !ext_rst) |=>
        (state_ff == ST_RUN) && $stable(cur_ff))
        else $error("abort did not stop the switch");

    cov_fail: cover property (
        (state_ff == ST_RUN) ##1 (state_ff == ST_F_GRP) ##[3:20]
        clock_fail_trap);
    cov_switch: cover property (
        (state_ff == ST_SWITCH) ##[1:50] $changed(cur_ff));
    cov_freeze: cover property (
        (state_ff == ST_FREEZE) ##[1:100] (state_ff == ST_RUN));
    cov_unlock: cover property (apply_lo ##[1:10] apply_hi);
endmodule

// *** testbench/cfsp_partner.sv ***
// Purpose: oscillator sources as seen by the clock block
// Assumes: fast rc never fails
// Notes: a new group becomes ready only after a slow start
`timescale 1ns/1ps
module cfsp_partner
    import cfsp_pkg::*;
#(
    parameter int READY_CYC = 6  // start-up of a new source
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       fail,
    input  wire logic [2:0] active_group,
    input  wire logic [2:0] osc_request_group,
    output logic            osc_running,
    output logic            oscillator_startup_done,
    output logic            pll_locked,
    output logic            group_ready,
    output logic            first_quadrature_phase
);
    logic [1:0] phase_ff;  // instruction clock phase
    logic [3:0] wait_ff;   // cycles since a switch was asked
    // one quadrature phase high out of four
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            phase_ff <= 2'h0;
        else
            phase_ff <= phase_ff + 2'h1;
    end
    // late answer on purpose, so the switch state is held a while
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            wait_ff <= 4'h0;
        else if (osc_request_group == active_group)
            wait_ff <= 4'h0;
        else if (wait_ff != 4'hf)
            wait_ff <= wait_ff + 4'h1;
    end
    assign first_quadrature_phase = (phase_ff == 2'h0);
    assign group_ready = (wait_ff >= READY_CYC);
    // a failed source stops; fast rc stays alive
    assign osc_running = !fail || (active_group == GRP_FRC);
    assign oscillator_startup_done = osc_running;
    assign pll_locked = osc_running;
endmodule

// *** testbench/cfsp_top_tb_top.sv ***
// Purpose: self-checking bench for the clock supervision block
// Assumes: shortened power-up counts
// Notes: reads are scored against a queue of notes
`timescale 1ns/1ps
module cfsp_top_tb_top
    import cfsp_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'h0;
    logic [2:0]  group_fuse = GRP_PRI;      // boot from primary
    logic [1:0]  switch_monitor_fuse = 2'h0; // switch and monitor on
    logic        watchdog_wake = 1'b0;
    logic        sleep_mode = 1'b0, soft_watchdog_enable = 1'b0;
    logic        pin_n = 1'b1;              // external reset pin level
    logic        fail = 1'b0;               // kills selected source
    logic [31:0] prdata;
    logic        pready, pslverr, osc_running, pll_locked, group_ready;
    logic        oscillator_startup_done, first_quadrature_phase;
    logic [2:0]  active_group, osc_request_group;
    logic [4:0]  primary_mode;
    logic        fast_rc_run, low_power_rc_enable;
    logic        clock_fail_trap, internal_system_reset;
    logic [32:0] exp_q[$];                  // {slverr, rdata}
    logic [32:0] note;
    int          mismatches = 0, tests_run = 0, traps = 0, n;
    integer      seed = 32'hc4a616a7;
    always #5 clk = ~clk;
    cfsp_top #(.PWRT4_CYC(20), .PWRT16_CYC(40), .PWRT64_CYC(80))
    u_cfsp_top (.clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .group_fuse,
        .primary_mode_fuse(5'h01), .switch_monitor_fuse,
        .power_up_timer_fuse(2'h1), .soft_watchdog_enable,
        .sleep_mode, .watchdog_wake, .external_reset_pin_n(pin_n),
        .first_quadrature_phase, .osc_running, .oscillator_startup_done,
        .pll_locked, .group_ready, .active_group, .primary_mode,
        .osc_request_group, .fast_rc_run, .low_power_rc_enable,
        .clock_fail_trap, .internal_system_reset);
    cfsp_partner u_cfsp_partner (.clk, .reset, .fail, .active_group,
        .osc_request_group, .osc_running, .oscillator_startup_done,
        .pll_locked, .group_ready, .first_quadrature_phase);
    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] g, e, input string m);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task automatic check_pin(input logic [2:0] g, e, input string m);
        check_word({29'h0, g}, {29'h0, e}, m);
    endtask
    // register image with pll locked and switch enable clear
    function automatic logic [31:0] img(logic [2:0] c, w, logic cf);
        img = {17'h0, c, 1'b0, w, 3'h1, 1'b0, cf, 3'h0};
    endfunction
    // one apb transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       input logic [32:0] e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        if (!w)
            exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, OSC_CTRL_OFS, d, s, 33'h0);
    endtask
    task automatic rd(input logic [31:0] e);
        apb(1'b0, OSC_CTRL_OFS, 32'h0, 4'h0, {1'b0, e});
    endtask
    // oldest note against each completed read; trap pulses counted
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            note = exp_q.pop_front();
            check_word(prdata, note[31:0], "read data");
            check_pin({2'h0, pslverr}, {2'h0, note[32]}, "slave error");
        end
        if (clock_fail_trap === 1'b1)
            traps++;
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (n = 0; n < 3000 && internal_system_reset !== 1'b0; n++)
            @(posedge clk);
        check_pin({2'h0, n >= 1020}, 3'h1, "early release");
        // a two-cycle pin glitch must not reach the core
        pin_n <= 1'b0;
        repeat (2) @(posedge clk);
        pin_n <= 1'b1;
        repeat (3) @(posedge clk);
        check_pin({2'h0, internal_system_reset}, 3'h0, "glitch");
        check_word({27'h0, primary_mode}, 32'h1, "primary opt");
        rd(img(GRP_PRI, GRP_PRI, 1'b0));
        apb(1'b0, 12'h004 | (12'($random(seed)) & 12'hffc), 32'h0, 4'h0,
            {1'b1, 32'h0});
        wr({16'h0, KEY_HI1, 8'h0}, STRB_HI);
        wr({16'h0, KEY_HI2, 8'h0}, STRB_HI);
        wr({21'h0, GRP_LOW_POWER_RC, 8'h0}, STRB_HI);
        rd(img(GRP_PRI, GRP_LOW_POWER_RC, 1'b0));
        // a read between the keys drops the unlock
        wr({16'h0, KEY_HI1, 8'h0}, STRB_HI);
        rd(img(GRP_PRI, GRP_LOW_POWER_RC, 1'b0));
        wr({16'h0, KEY_HI2, 8'h0}, STRB_HI);
        wr($random(seed), STRB_HI);
        rd(img(GRP_PRI, GRP_LOW_POWER_RC, 1'b0));
        // target low_power_rc stays above the slowest safe clock
        wr({24'h0, KEY_LO1}, STRB_LO);
        wr({24'h0, KEY_LO2}, STRB_LO);
        wr(32'h0000_0001, STRB_LO);
        repeat (2) @(posedge clk);
        #1 check_pin(osc_request_group, GRP_LOW_POWER_RC, "no switch");
        for (n = 0; n < 50 && active_group !== GRP_LOW_POWER_RC; n++)
            @(posedge clk);
        rd(img(GRP_LOW_POWER_RC, GRP_LOW_POWER_RC, 1'b0));
        check_pin({2'h0, low_power_rc_enable}, 3'h1, "low_power_rc off");
        fail <= 1'b1;
        for (n = 0; n < 50 && traps == 0; n++)
            @(posedge clk);
        #1 check_pin(active_group, GRP_FRC, "not on fast rc");
        check_pin({2'h0, fast_rc_run}, 3'h1, "fast rc idle");
        @(posedge clk) watchdog_wake <= 1'b1;
        @(posedge clk) watchdog_wake <= 1'b0;
        rd(img(GRP_FRC, GRP_LOW_POWER_RC, 1'b1));
        // fuses take over; monitor off, dead source must not trap
        switch_monitor_fuse <= 2'h2;
        group_fuse <= GRP_SEC;
        repeat (20) @(posedge clk);
        #1 check_pin(active_group, GRP_SEC, "fuse ignored");
        check_pin(traps[2:0], 3'h1, "trap count");
        finish_test();
    end
    // run needs about 1100 cycles; 20000 means a hang
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule
